// ==== verilog/snr_feature_regs.sv ====
// feature register bank of a serial nand device, seen through its serial pins
// assumes spi mode 0 on sck, engine status on core_clk, power-on reset on nrst
//
// Behaviour
// - ecc status codes only meaningful while ecc enable is set
// - every feature bit returns to its default at power-on
// - wp low with write-disable set blocks writes to it and lock bits
// - lock field 000 none, 001..110 upper fractions, 111 all (default)
// - protect enable defaults 0; when 1 protect-execute is accepted
// - id read enable defaults 0; when 1 parameter and id read mode
// - ecc enable switches internal correction, resets to 1
// - bad block inhibit bit is read-only and reads 1
// - fast read enable selects high speed page read, resets to 1
// - ecc result: 00 clean, 01 low, 10 uncorrected, 11 high
// - corrected count compared against threshold from engine input flip_threshold
// - program fail bit follows result of last program or protect
// - erase fail bit follows result of last erase
// - write enable latch bit reports write enable, default 0
// - set feature cannot change latch; only 06h sets, 04h clears
// - busy bit is 1 while busy, 0 when ready
// - get feature repeats the addressed byte while reading continues
// - busy and fail bits refresh live during repeated status output
// - reserved bits read as zero
// - undefined feature addresses are not used by the host
// - chip select high ends output; device stops driving
// - settings survive reset commands, lost only at power-off
`timescale 1ns/1ps
module snr_feature_regs (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic wp_n,
  input wire snr_pkg::snr_engine_t eng,
  output snr_pkg::snr_cfg_t cfg,
  output snr_pkg::snr_status_t status
);
  import snr_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic tgl_edge(input logic [2:0] sync);
    tgl_edge = sync[2] ^ sync[1];
  endfunction

  function automatic logic [7:0] sel_byte(input logic [7:0] a, input logic [23:0] sn);
    case (a)
      ADDR_LOCK: sel_byte = sn[23:16];
      ADDR_FEAT: sel_byte = sn[15:8];
      ADDR_STAT: sel_byte = sn[7:0];
      default: sel_byte = 8'h00;
    endcase
  endfunction

  function automatic logic [1:0] ecc_code(input snr_engine_t e);
    if (e.ecc_uncorr) begin
      ecc_code = ECC_UNCORR;
    end else if (e.ecc_flips == 4'h0) begin
      ecc_code = ECC_CLEAN;
    end else if (e.ecc_flips < e.flip_threshold) begin
      ecc_code = ECC_CORR_LOW;
    end else begin
      ecc_code = ECC_CORR_HIGH;
    end
  endfunction

  snr_core_t s;
  snr_core_t next_s;
  snr_frame_t f;
  snr_frame_t next_f;
  snr_hold_t h;
  snr_hold_t next_h;
  snr_out_t o;
  snr_out_t next_o;
  logic frame_rst_n;
  logic wr_fire;
  logic wels_fire;
  logic welc_fire;
  logic wp_low;
  logic [7:0] live_lock;
  logic [7:0] live_feat;
  logic [7:0] live_stat;
  logic [7:0] sh;
  logic byte_done;

  // ----------------------------------------
  // core side: registers and status
  // ----------------------------------------
  always_comb begin
    live_lock = 8'h00;
    live_lock[LRWD_BIT] = s.cfg.lock_reg_write_disable;
    live_lock[LOCK_LSB +: 3] = s.cfg.lock_range;
    live_feat = 8'h00;
    live_feat[PE_BIT] = s.cfg.protect_enable;
    live_feat[IDR_BIT] = s.cfg.id_read_enable;
    live_feat[ECCEN_BIT] = s.cfg.ecc_enable;
    live_feat[BBI_BIT] = BBI_VAL;
    live_feat[FAST_BIT] = s.cfg.fast_read_enable;
    live_stat = 8'h00;
    live_stat[ECCR_LSB +: 2] = s.stat.ecc_result;
    live_stat[PFAIL_BIT] = s.stat.program_fail;
    live_stat[EFAIL_BIT] = s.stat.erase_fail;
    live_stat[WEL_BIT] = s.stat.write_enable_latch;
    live_stat[BUSY_BIT] = s.stat.busy_flag;
  end

  assign wr_fire = tgl_edge(s.wr_sync);
  assign wels_fire = tgl_edge(s.wels_sync);
  assign welc_fire = tgl_edge(s.welc_sync);
  assign wp_low = ~s.wp_sync[1];

  always_comb begin
    next_s = s;
    next_s.wp_sync = {s.wp_sync[0], wp_n};
    next_s.wr_sync = {s.wr_sync[1:0], h.wr_tgl};
    next_s.wels_sync = {s.wels_sync[1:0], h.wels_tgl};
    next_s.welc_sync = {s.welc_sync[1:0], h.welc_tgl};
    next_s.ack_sync = {s.ack_sync[0], h.ack};
    if (wr_fire) begin
      case (h.wr_addr)
        ADDR_LOCK: begin
          if (!(wp_low && s.cfg.lock_reg_write_disable)) begin
            next_s.cfg.lock_reg_write_disable = h.wr_data[LRWD_BIT];
            next_s.cfg.lock_range = h.wr_data[LOCK_LSB +: 3];
          end
        end
        ADDR_FEAT: begin
          next_s.cfg.protect_enable = h.wr_data[PE_BIT];
          next_s.cfg.id_read_enable = h.wr_data[IDR_BIT];
          next_s.cfg.ecc_enable = h.wr_data[ECCEN_BIT];
          next_s.cfg.fast_read_enable = h.wr_data[FAST_BIT];
        end
        default: begin
        end
      endcase
    end
    if (welc_fire) begin
      next_s.stat.write_enable_latch = 1'b0;
    end
    if (wels_fire) begin
      next_s.stat.write_enable_latch = 1'b1;
    end
    next_s.stat.busy_flag = eng.busy;
    if (eng.prog_done) begin
      next_s.stat.program_fail = eng.prog_fail;
    end
    if (eng.erase_done) begin
      next_s.stat.erase_fail = eng.erase_fail;
    end
    if (eng.ecc_done) begin
      next_s.stat.ecc_result = s.cfg.ecc_enable ? ecc_code(eng) : ECC_CLEAN;
    end
    if (s.ack_sync[1] == s.req && {live_lock, live_feat, live_stat} != s.snap) begin
      next_s.snap = {live_lock, live_feat, live_stat};
      next_s.req = ~s.req;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.cfg.lock_reg_write_disable <= LRWD_RST;
      s.cfg.lock_range <= LOCK_RST;
      s.cfg.protect_enable <= PE_RST;
      s.cfg.id_read_enable <= IDR_RST;
      s.cfg.ecc_enable <= ECCEN_RST;
      s.cfg.fast_read_enable <= FAST_RST;
      s.stat.write_enable_latch <= WEL_RST;
    end else begin
      s <= next_s;
    end
  end

  assign cfg = s.cfg;
  assign status = s.stat;

  // ----------------------------------------
  // link side: serial frame on sck
  // ----------------------------------------
  // chip select high clears the frame
  assign frame_rst_n = nrst & ~cs_n;
  assign sh = {f.shift[6:0], si};
  assign byte_done = (f.cnt == 3'h7);

  always_comb begin
    next_f = f;
    next_h = h;
    next_f.shift = sh;
    next_f.cnt = f.cnt + 3'h1;
    next_h.req_sync = {h.req_sync[0], s.req};
    if (h.req_sync[1] != h.ack) begin
      next_h.snap = s.snap;
      next_h.ack = h.req_sync[1];
    end
    case (f.phase)
      PH_CMD: begin
        if (byte_done) begin
          next_f.cmd = sh;
          next_f.phase = PH_IDLE;
          case (sh)
            CMD_SET_FEATURE, CMD_GET_FEATURE: begin
              next_f.phase = PH_ADDR;
            end
            CMD_WEL_SET: begin
              next_h.wels_tgl = ~h.wels_tgl;
            end
            CMD_WEL_CLR: begin
              next_h.welc_tgl = ~h.welc_tgl;
            end
            default: begin
            end
          endcase
        end
      end
      PH_ADDR: begin
        if (byte_done) begin
          next_f.addr = sh;
          next_f.phase = PH_DATA;
          next_f.obyte = sel_byte(sh, h.snap);
        end
      end
      PH_DATA: begin
        if (byte_done) begin
          if (f.cmd == CMD_SET_FEATURE) begin
            next_h.wr_addr = f.addr;
            next_h.wr_data = sh;
            next_h.wr_tgl = ~h.wr_tgl;
            next_f.phase = PH_IDLE;
          end else begin
            next_f.obyte = sel_byte(f.addr, h.snap);
          end
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      h <= '0;
    end else begin
      h <= next_h;
    end
  end

  // ----------------------------------------
  // serial output on falling sck
  // ----------------------------------------
  always_comb begin
    next_o.so_oe = (f.phase == PH_DATA) && (f.cmd == CMD_GET_FEATURE);
    next_o.so = next_o.so_oe ? f.obyte[3'h7 - f.cnt] : 1'b0;
  end

  // release line at chip select high
  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  assign so = o.so;
  assign so_oe = o.so_oe;

  // ----------------------------------------
  // checks on the core side
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  lock_guard_a: assert property (
    wr_fire && h.wr_addr == ADDR_LOCK && wp_low && s.cfg.lock_reg_write_disable
    |=> $stable(s.cfg.lock_range) && s.cfg.lock_reg_write_disable)
    else $error("lock bits changed while write disabled");

  lock_write_a: assert property (
    wr_fire && h.wr_addr == ADDR_LOCK && !wp_low
    |=> s.cfg.lock_range == $past(h.wr_data[5:3]))
    else $error("lock range not stored");

  wel_set_a: assert property (
    wels_fire |=> s.stat.write_enable_latch ##1 s.stat.write_enable_latch || welc_fire)
    else $error("latch not set by enable command");

  wel_setfeat_a: assert property (
    wr_fire && !wels_fire && !welc_fire |=> $stable(s.stat.write_enable_latch))
    else $error("set feature changed write latch");

  ecc_off_a: assert property (
    eng.ecc_done && !s.cfg.ecc_enable |=> s.stat.ecc_result == ECC_CLEAN)
    else $error("ecc result while ecc disabled");

  ecc_high_a: assert property (
    eng.ecc_done && s.cfg.ecc_enable && !eng.ecc_uncorr && eng.ecc_flips != 4'h0
    && eng.ecc_flips >= eng.flip_threshold |=> s.stat.ecc_result == ECC_CORR_HIGH)
    else $error("high corrected code wrong");

  ecc_uncorr_a: assert property (
    eng.ecc_done && s.cfg.ecc_enable && eng.ecc_uncorr
    |=> s.stat.ecc_result == ECC_UNCORR)
    else $error("uncorrected code wrong");

  prog_fail_a: assert property (
    eng.prog_done |=> s.stat.program_fail == $past(eng.prog_fail))
    else $error("program fail not captured");

  erase_fail_a: assert property (
    eng.erase_done |=> s.stat.erase_fail == $past(eng.erase_fail))
    else $error("erase fail not captured");

  busy_track_a: assert property (
    eng.busy [*2] |=> s.stat.busy_flag)
    else $error("busy bit not held");

  reserved_zero_a: assert property (
    live_lock[2:0] == 3'h0 && live_lock[6] == 1'b0 && live_feat[5] == 1'b0
    && live_feat[3] == 1'b0 && live_feat[0] == 1'b0 && live_stat[7:6] == 2'h0)
    else $error("reserved bit nonzero");

  bbi_fixed_a: assert property (
    wr_fire && h.wr_addr == ADDR_FEAT |=> live_feat[BBI_BIT] == BBI_VAL)
    else $error("bad block inhibit bit changed");

  wel_clear_a: assert property (
    welc_fire && !wels_fire |=> !s.stat.write_enable_latch)
    else $error("latch not cleared by disable command");

  feat_store_a: assert property (
    wr_fire && h.wr_addr == ADDR_FEAT
    |=> s.cfg.ecc_enable == $past(h.wr_data[ECCEN_BIT])
    && s.cfg.fast_read_enable == $past(h.wr_data[FAST_BIT]))
    else $error("feature enables not stored");

  stat_ro_a: assert property (
    wr_fire && h.wr_addr == ADDR_STAT
    && !eng.prog_done && !eng.erase_done && !eng.ecc_done
    |=> $stable(s.stat.ecc_result) && $stable(s.stat.program_fail)
    && $stable(s.stat.erase_fail))
    else $error("status bits changed by a write");

endmodule

// ==== verilog/snr_pkg.sv ====
// feature register bank: constants, states and carrier types
// assumes a serial flash core with an array engine on core_clk
package snr_pkg;

  // ----------------------------------------
  // feature addresses and serial commands
  // ----------------------------------------
  localparam logic [7:0] ADDR_LOCK = 8'hA0;
  localparam logic [7:0] ADDR_FEAT = 8'hB0;
  localparam logic [7:0] ADDR_STAT = 8'hC0;
  localparam logic [7:0] CMD_SET_FEATURE = 8'h1F;
  localparam logic [7:0] CMD_GET_FEATURE = 8'h0F;
  localparam logic [7:0] CMD_WEL_SET = 8'h06;
  localparam logic [7:0] CMD_WEL_CLR = 8'h04;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int LRWD_BIT = 7;
  localparam int LOCK_LSB = 3;
  localparam int PE_BIT = 7;
  localparam int IDR_BIT = 6;
  localparam int ECCEN_BIT = 4;
  localparam int BBI_BIT = 2;
  localparam int FAST_BIT = 1;
  localparam int ECCR_LSB = 4;
  localparam int PFAIL_BIT = 3;
  localparam int EFAIL_BIT = 2;
  localparam int WEL_BIT = 1;
  localparam int BUSY_BIT = 0;

  // ----------------------------------------
  // values after power-on
  // ----------------------------------------
  localparam logic LRWD_RST = 1'h0;
  localparam logic [2:0] LOCK_RST = 3'h7;
  localparam logic PE_RST = 1'h0;
  localparam logic IDR_RST = 1'h0;
  localparam logic ECCEN_RST = 1'h1;
  localparam logic BBI_VAL = 1'h1;
  localparam logic FAST_RST = 1'h1;
  localparam logic WEL_RST = 1'h0;

  // ----------------------------------------
  // ecc result and lock range codes
  // ----------------------------------------
  localparam logic [1:0] ECC_CLEAN = 2'h0;
  localparam logic [1:0] ECC_CORR_LOW = 2'h1;
  localparam logic [1:0] ECC_UNCORR = 2'h2;
  localparam logic [1:0] ECC_CORR_HIGH = 2'h3;
  localparam logic [2:0] LOCK_NONE = 3'h0;
  localparam logic [2:0] LOCK_ALL = 3'h7;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PH_CMD = 2'h0,
    PH_ADDR = 2'h1,
    PH_DATA = 2'h3,
    PH_IDLE = 2'h2
  } snr_phase_t;

  typedef struct packed {
    logic busy;
    logic prog_done;
    logic prog_fail;
    logic erase_done;
    logic erase_fail;
    logic ecc_done;
    logic ecc_uncorr;
    logic [3:0] ecc_flips;
    logic [3:0] flip_threshold;
  } snr_engine_t;

  typedef struct packed {
    logic lock_reg_write_disable;
    logic [2:0] lock_range;
    logic protect_enable;
    logic id_read_enable;
    logic ecc_enable;
    logic fast_read_enable;
  } snr_cfg_t;

  typedef struct packed {
    logic [1:0] ecc_result;
    logic program_fail;
    logic erase_fail;
    logic write_enable_latch;
    logic busy_flag;
  } snr_status_t;

  typedef struct packed {
    logic [1:0] wp_sync;
    logic [2:0] wr_sync;
    logic [2:0] wels_sync;
    logic [2:0] welc_sync;
    logic [1:0] ack_sync;
    logic req;
    logic [23:0] snap;
    snr_cfg_t cfg;
    snr_status_t stat;
  } snr_core_t;

  typedef struct packed {
    snr_phase_t phase;
    logic [2:0] cnt;
    logic [7:0] shift;
    logic [7:0] cmd;
    logic [7:0] addr;
    logic [7:0] obyte;
  } snr_frame_t;

  typedef struct packed {
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_tgl;
    logic wels_tgl;
    logic welc_tgl;
    logic [1:0] req_sync;
    logic ack;
    logic [23:0] snap;
  } snr_hold_t;

  typedef struct packed {
    logic so;
    logic so_oe;
  } snr_out_t;

endpackage

// ==== verification/snr_host_model.sv ====
// host side of the serial link: frames with a gated 48 ns clock
// assumes the device samples on rising sck and drives on falling sck
`timescale 1ns/1ps
module snr_host_model (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic oe_bad;

  initial begin
    oe_bad = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // ----------------------------------------
  // one frame: n_out bits sent msb first, then n_in bits read
  // ----------------------------------------
  // only defined feature addresses are sent by callers
  task automatic xfer(input logic [23:0] bits, input int n_out, input int n_in,
                      output logic [31:0] rd);
    rd = 32'h0000_0000;
    oe_bad = 1'b0;
    cs_n = 1'b0;
    #24;
    for (int i = 0; i < n_out + n_in; i++) begin
      si = (i < n_out) ? bits[23-i] : ~si;
      #24 sck = 1'b1;
      if (so_oe !== ((i >= n_out) && (n_in > 0))) begin
        oe_bad = 1'b1;
      end
      if (i >= n_out) begin
        rd = {rd[30:0], so};
      end
      #24 sck = 1'b0;
    end
    #24;
    cs_n = 1'b1;
    si = ~si;
    #48;
  endtask
endmodule

// ==== verification/tb_snr_feature_regs.sv ====
// self-checking bench for the feature register bank
// assumes the host model drives the link and the bench drives the engine
`timescale 1ns/1ps
module tb_snr_feature_regs;
  import snr_pkg::*;
  logic core_clk, nrst, wp_n, sck, cs_n, si, so, so_oe;
  snr_engine_t eng;
  snr_cfg_t cfg;
  snr_status_t status;
  int n_mismatch, checks_done, seed;
  logic [31:0] rd;
  logic [7:0] d;
  logic [3:0] fl, th;

  snr_feature_regs i_snr_feature_regs (.core_clk(core_clk), .nrst(nrst), .sck(sck),
    .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n), .eng(eng), .cfg(cfg),
    .status(status));
  snr_host_model i_snr_host_model (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

  always #10 core_clk = ~core_clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (6) @(posedge core_clk);
    #2;
  endtask
  task automatic set_feat(input logic [7:0] a, input logic [7:0] v);
    i_snr_host_model.xfer({CMD_SET_FEATURE, a, v}, 24, 0, rd);
    chk("so_oe quiet", {7'h00, i_snr_host_model.oe_bad}, 8'h00);
    settle();
  endtask
  task automatic cmd_only(input logic [7:0] c);
    i_snr_host_model.xfer({c, 16'h0000}, 8, 0, rd);
    settle();
  endtask
  task automatic get_feat(input logic [7:0] a, input int nb);
    i_snr_host_model.xfer({CMD_GET_FEATURE, a, 8'h00}, 16, 8 * nb, rd);
    chk("so_oe idle", {so, so_oe}, 8'h00);
    chk("so_oe window", {7'h00, i_snr_host_model.oe_bad}, 8'h00);
  endtask
  task automatic eng_pulse(input int kind, input logic fail, input logic unc,
                           input logic [3:0] f);
    @(posedge core_clk);
    #2;
    eng.prog_done = (kind == 0);
    eng.erase_done = (kind == 1);
    eng.ecc_done = (kind == 2);
    eng.prog_fail = fail;
    eng.erase_fail = fail;
    eng.ecc_uncorr = unc;
    eng.ecc_flips = f;
    @(posedge core_clk);
    #2;
    eng.prog_done = 1'b0;
    eng.erase_done = 1'b0;
    eng.ecc_done = 1'b0;
    settle();
  endtask
  function automatic logic [7:0] exp_feat(input logic [7:0] v);
    return {v[7], v[6], 1'b0, v[4], 1'b0, BBI_VAL, v[1], 1'b0};
  endfunction
  function automatic logic [1:0] exp_ecc(input logic u, input logic [3:0] f,
                                         input logic [3:0] t, input logic en);
    if (!en || (!u && f == 4'h0)) return ECC_CLEAN;
    if (u) return ECC_UNCORR;
    return (f < t) ? ECC_CORR_LOW : ECC_CORR_HIGH;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 40;
    core_clk = 1'b0;
    nrst = 1'b0;
    wp_n = 1'b1;
    eng = '0;
    eng.flip_threshold = 4'h4;
    repeat (12) @(posedge core_clk);
    #2;
    nrst = 1'b1;
    settle();
    chk("cfg reset", cfg, 8'h73);
    chk("status reset", {2'b00, status}, 8'h00);
    get_feat(ADDR_LOCK, 1);
    chk("lock reset", rd[7:0], 8'h38);
    get_feat(ADDR_FEAT, 1);
    chk("feat reset", rd[7:0], 8'h16);
    get_feat(ADDR_STAT, 1);
    chk("stat reset", rd[7:0], 8'h00);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      set_feat(ADDR_FEAT, d);
      get_feat(ADDR_FEAT, 1);
      chk("feat readback", rd[7:0], exp_feat(d));
      chk("cfg enables", {cfg.protect_enable, cfg.id_read_enable, cfg.ecc_enable,
        cfg.fast_read_enable}, {4'h0, d[7], d[6], d[4], d[1]});
    end
    $display("test feature random done");
    for (int i = 0; i < 8; i++) begin
      set_feat(ADDR_LOCK, {2'b01, i[2:0], 3'b111});
      get_feat(ADDR_LOCK, 1);
      chk("lock readback", rd[7:0], {2'b00, i[2:0], 3'b000});
      chk("lock cfg", {5'h00, cfg.lock_range}, {5'h00, i[2:0]});
    end
    set_feat(ADDR_LOCK, 8'h90);
    wp_n = 1'b0;
    settle();
    set_feat(ADDR_LOCK, 8'h00);
    get_feat(ADDR_LOCK, 1);
    chk("lock protected", rd[7:0], 8'h90);
    wp_n = 1'b1;
    settle();
    set_feat(ADDR_LOCK, 8'h00);
    get_feat(ADDR_LOCK, 1);
    chk("lock released", rd[7:0], 8'h00);
    $display("test lock done");
    set_feat(ADDR_STAT, 8'h02);
    chk("latch via set", {7'h00, status.write_enable_latch}, 8'h00);
    cmd_only(CMD_WEL_SET);
    get_feat(ADDR_STAT, 1);
    chk("latch set", rd[7:0], 8'h02);
    cmd_only(CMD_WEL_CLR);
    get_feat(ADDR_STAT, 1);
    chk("latch clear", rd[7:0], 8'h00);
    $display("test latch done");
    set_feat(ADDR_FEAT, 8'h12);
    cmd_only(8'hFF);
    get_feat(ADDR_FEAT, 1);
    chk("feat after reset cmd", rd[7:0], 8'h16);
    for (int i = 0; i < 10; i++) begin
      fl = (i < 4) ? 4'(3 + i / 3) : 4'($random(seed));
      th = (i < 4) ? 4'h4 : 4'($random(seed));
      fl = (i == 1) ? 4'h0 : fl;
      eng.flip_threshold = th;
      eng_pulse(2, 1'b0, (i == 0), fl);
      get_feat(ADDR_STAT, 1);
      chk("ecc result", rd[7:0], {2'b00, exp_ecc(i == 0, fl, th, 1'b1), 4'h0});
    end
    set_feat(ADDR_FEAT, 8'h02);
    eng_pulse(2, 1'b0, 1'b1, 4'h5);
    chk("ecc disabled", {6'h00, status.ecc_result}, 8'h00);
    $display("test ecc done");
    eng_pulse(0, 1'b1, 1'b0, 4'h0);
    get_feat(ADDR_STAT, 1);
    chk("program fail", rd[7:0], 8'h08);
    eng_pulse(1, 1'b1, 1'b0, 4'h0);
    get_feat(ADDR_STAT, 1);
    chk("erase fail", rd[7:0], 8'h0C);
    eng_pulse(0, 1'b0, 1'b0, 4'h0);
    eng_pulse(1, 1'b0, 1'b0, 4'h0);
    get_feat(ADDR_STAT, 1);
    chk("fails passed", rd[7:0], 8'h00);
    $display("test fail flags done");
    eng.busy = 1'b1;
    settle();
    fork
      get_feat(ADDR_STAT, 4);
      begin
        #960;
        @(posedge core_clk);
        #2;
        eng.busy = 1'b0;
      end
    join
    chk("busy first byte", rd[31:24], 8'h01);
    chk("busy live byte", rd[7:0], 8'h00);
    $display("test busy done");
    tally_and_finish();
  end
endmodule
